// ### timer_pair_regs.vh
// Register offsets, field positions, reset values and timing counts of the timer pair.
// Behaviour
// - Each timer shows its present 24-bit count, read only, in bits 23 to 0 of its current-value register, zero after reset.
// - Control bit 2 masks the timer's interrupt when one and lets it through when zero, resetting to zero.
// - Control bit 1 picks free-running mode at zero and user-defined count mode, using the load count, at one, resetting to zero.
// - Reading a timer's interrupt-clear register returns zero and clears that timer's pending interrupt.
// - The read-only interrupt flag register shows the pending interrupt gated by control bit 2 in bit 0 with bits 31 to 1 reading zero.
// - The second timer has its own writable 24-bit load count, resetting to zero.
// - The first timer has a writable 24-bit load count that is loaded when counting starts and on reload in user-defined count mode.
// - Both timers count on a 4 MHz timer clock.
`ifndef TIMER_PAIR_REGS_VH
`define TIMER_PAIR_REGS_VH

`define FIRST_RELOAD_OFS     8'h00
`define FIRST_COUNT_OFS      8'h04
`define FIRST_CONTROL_OFS    8'h08
`define FIRST_CLEAR_OFS      8'h0C
`define FIRST_FLAG_OFS       8'h10
`define SECOND_RELOAD_OFS    8'h14
`define SECOND_COUNT_OFS     8'h18
`define SECOND_CONTROL_OFS   8'h1C
`define SECOND_CLEAR_OFS     8'h20
`define SECOND_FLAG_OFS      8'h24

`define CTRL_ENABLE_BIT      0
`define CTRL_MODE_BIT        1
`define CTRL_MASK_BIT        2
`define CTRL_RESET           3'h0
`define COUNT_WIDTH          24
`define COUNT_RESET          24'h000000
`define COUNT_ALL_ONES       24'hFFFFFF

`define MCLK_HZ              25000000
`define TICK_HZ              4000000
`define TICK_STEP            5'h04
`define TICK_MODULUS         5'h19

`endif

// ### timer_channel.v
// One 24-bit down-counting timer with its pending interrupt flag.
`timescale 1ns/100ps
`default_nettype none
`include "timer_pair_regs.vh"
module timer_channel
(
    input  wire        mclk,
    input  wire        reset_n,
    input  wire        tick,
    input  wire        enable,
    input  wire        user_mode,
    input  wire [23:0] reload_value,
    input  wire        clear,
    output reg  [23:0] count_now,
    output reg         pending
);
    reg armed;

    always @(posedge mclk)
    begin
        if (!reset_n)
        begin
            count_now <= `COUNT_RESET;
            armed     <= 1'b0;
            pending   <= 1'b0;
        end
        else
        begin
            if (!enable)
                armed <= 1'b0;
            else if (tick)
            begin
                if (!armed)
                begin
                    count_now <= reload_value;
                    armed     <= 1'b1;
                end
                else if (count_now == `COUNT_RESET)
                begin
                    count_now <= user_mode ? reload_value : `COUNT_ALL_ONES;
                end
                else
                    count_now <= count_now - 24'h000001;
            end
            if (enable && tick && armed && count_now == `COUNT_RESET)
                pending <= 1'b1;
            else if (clear)
                pending <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ### timer_pair.v
// AHB-Lite register slave and tick divider for the pair of 24-bit timers.
//
// Our own choice: the AHB-Lite register port.
`timescale 1ns/100ps
`default_nettype none
`include "timer_pair_regs.vh"
module timer_pair
(
    input  wire        mclk,
    input  wire        reset_n,
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire        hready,
    input  wire [31:0] hwdata,
    output reg  [31:0] hrdata,
    output reg         hreadyout,
    output reg         hresp,
    output reg         first_timer_irq,
    output reg         second_timer_irq
);
    reg  [4:0]  tick_acc;
    reg         tick;
    reg         busy;
    reg         phase_write;
    reg  [7:0]  phase_addr;
    reg  [23:0] first_timer_reload_value;
    reg  [23:0] second_timer_reload_value;
    reg  [2:0]  first_timer_control;
    reg  [2:0]  second_timer_control;
    reg         first_clear;
    reg         second_clear;
    reg  [31:0] next_hrdata;
    wire [23:0] first_timer_count_now;
    wire [23:0] second_timer_count_now;
    wire        first_pending;
    wire        second_pending;
    wire        take;
    wire        do_read;
    wire        do_write;
    wire [5:0]  acc_sum;
    // Per-channel signals packed side by side, first timer in the low slice.
    wire [47:0] reload_bus;
    wire [5:0]  control_bus;
    wire [1:0]  clear_bus;
    wire [47:0] count_bus;
    wire [1:0]  pending_bus;
    genvar      ch;

    assign take     = hsel && htrans[1] && hready;
    assign do_read  = busy && !phase_write;
    assign do_write = busy && phase_write;
    assign acc_sum  = {1'b0, tick_acc} + {1'b0, `TICK_STEP};

    assign reload_bus             = {second_timer_reload_value, first_timer_reload_value};
    assign control_bus            = {second_timer_control, first_timer_control};
    assign clear_bus              = {second_clear, first_clear};
    assign first_timer_count_now  = count_bus[23:0];
    assign second_timer_count_now = count_bus[47:24];
    assign first_pending          = pending_bus[0];
    assign second_pending         = pending_bus[1];

    // The 25 MHz clock is not a whole multiple of 4 MHz, so a fractional
    // accumulator spaces the ticks 6 or 7 cycles apart, exact on average.
    // 4 MHz tick
    always @(posedge mclk)
    begin
        if (!reset_n)
        begin
            tick_acc <= 5'h00;
            tick     <= 1'b0;
        end
        else if (acc_sum >= {1'b0, `TICK_MODULUS})
        begin
            tick_acc <= acc_sum[4:0] - `TICK_MODULUS;
            tick     <= 1'b1;
        end
        else
        begin
            tick_acc <= acc_sum[4:0];
            tick     <= 1'b0;
        end
    end

    // Read mux; reserved bits and unmapped addresses read zero.
    always @*
    begin
        next_hrdata = 32'h00000000;
        case (phase_addr)
            `FIRST_RELOAD_OFS:   next_hrdata = {8'h00, first_timer_reload_value};
            `FIRST_COUNT_OFS:    next_hrdata = {8'h00, first_timer_count_now};
            `FIRST_CONTROL_OFS:  next_hrdata = {29'h0, first_timer_control};
            `FIRST_FLAG_OFS:
                next_hrdata = {31'h0,
                    first_pending & ~first_timer_control[`CTRL_MASK_BIT]};
            `SECOND_RELOAD_OFS:  next_hrdata = {8'h00, second_timer_reload_value};
            `SECOND_COUNT_OFS:   next_hrdata = {8'h00, second_timer_count_now};
            `SECOND_CONTROL_OFS: next_hrdata = {29'h0, second_timer_control};
            `SECOND_FLAG_OFS:
                next_hrdata = {31'h0,
                    second_pending & ~second_timer_control[`CTRL_MASK_BIT]};
            default:             next_hrdata = 32'h00000000;
        endcase
    end

    // Every transfer gets one wait state so that read data leave a flop.
    always @(posedge mclk)
    begin
        if (!reset_n)
        begin
            busy                      <= 1'b0;
            phase_write               <= 1'b0;
            phase_addr                <= 8'h00;
            hreadyout                 <= 1'b1;
            hresp                     <= 1'b0;
            hrdata                    <= 32'h00000000;
            first_timer_reload_value  <= `COUNT_RESET;
            second_timer_reload_value <= `COUNT_RESET;
            first_timer_control       <= `CTRL_RESET;
            second_timer_control      <= `CTRL_RESET;
        end
        else
        begin
            // Address phases seen while busy are ignored; hready is low, so the master holds them.
            if (busy)
            begin
                busy      <= 1'b0;
                hreadyout <= 1'b1;
                hrdata    <= do_read ? next_hrdata : 32'h00000000;
            end
            else if (take)
            begin
                busy        <= 1'b1;
                hreadyout   <= 1'b0;
                phase_write <= hwrite;
                phase_addr  <= {haddr[7:2], 2'b00};
            end
            if (do_write)
            begin
                case (phase_addr)
                    `FIRST_RELOAD_OFS:
                        first_timer_reload_value <= hwdata[23:0];
                    `FIRST_CONTROL_OFS:
                        first_timer_control <= hwdata[2:0];
                    `SECOND_RELOAD_OFS:
                        second_timer_reload_value <= hwdata[23:0];
                    `SECOND_CONTROL_OFS:
                        second_timer_control <= hwdata[2:0];
                    // Count, clear and flag registers ignore writes.
                    default:
                        hresp <= 1'b0;
                endcase
            end
        end
    end

    // The strobe rises on the read's data edge and the flag drops a cycle later,
    // after the read itself has already returned the zero word.
    // read clears pending
    always @(posedge mclk)
    begin
        if (!reset_n)
        begin
            first_clear  <= 1'b0;
            second_clear <= 1'b0;
        end
        else
        begin
            first_clear  <= do_read && phase_addr == `FIRST_CLEAR_OFS;
            second_clear <= do_read && phase_addr == `SECOND_CLEAR_OFS;
        end
    end

    // The outputs are registered, so they trail the flag register by a cycle.
    // mask gates output
    always @(posedge mclk)
    begin
        if (!reset_n)
        begin
            first_timer_irq  <= 1'b0;
            second_timer_irq <= 1'b0;
        end
        else
        begin
            first_timer_irq  <= first_pending & ~first_timer_control[`CTRL_MASK_BIT];
            second_timer_irq <= second_pending & ~second_timer_control[`CTRL_MASK_BIT];
        end
    end

    // One channel per entry; both share the divider's tick, so they step together.
    generate
        for (ch = 0; ch < 2; ch = ch + 1)
        begin : channel
            timer_channel timer_channel_inst
            (
                .mclk         (mclk),
                .reset_n      (reset_n),
                .tick         (tick),
                .enable       (control_bus[ch*3 + `CTRL_ENABLE_BIT]),
                .user_mode    (control_bus[ch*3 + `CTRL_MODE_BIT]),
                .reload_value (reload_bus[ch*24 +: 24]),
                .clear        (clear_bus[ch]),
                .count_now    (count_bus[ch*24 +: 24]),
                .pending      (pending_bus[ch])
            );
        end
    endgenerate
endmodule
`default_nettype wire

// ### timer_pair_checker.sv
// Assertions on the timer pair bus slave and interrupt outputs.
`timescale 1ns/100ps
`default_nettype none
module timer_pair_checker
(
    input wire logic        mclk,
    input wire logic        reset_n,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [2:0]  hsize,
    input wire logic        hready,
    input wire logic [31:0] hwdata,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        first_timer_irq,
    input wire logic        second_timer_irq
);
    wire take = hsel && htrans[1] && hready;
    wire rd   = take && !hwrite;
    default clocking dc @(posedge mclk);
    endclocking
    default disable iff (!reset_n);
    wait_state_a: assert property (take |=> !hreadyout ##1 hreadyout)
        else $error("bus answer not after one wait state");
    resp_okay_a: assert property (!hresp)
        else $error("error response seen");
    irq_reset_a: assert property (disable iff (1'b0) !reset_n |=> !first_timer_irq && !second_timer_irq)
        else $error("interrupt high after reset");
    clear_zero_a: assert property (rd && haddr[7:0] == 8'h0C |=> ##1 hrdata == 32'h0)
        else $error("clear register read not zero");
    flag_upper_a: assert property (rd && haddr[7:0] == 8'h10 |=> ##1 hrdata[31:1] == 31'h0)
        else $error("flag upper bits not zero");
    count_upper_a: assert property (rd && haddr[7:0] == 8'h04 |=> ##1 hrdata[31:24] == 8'h0)
        else $error("count upper bits not zero");
    load_upper_a: assert property (rd && haddr[7:0] == 8'h14 |=> ##1 hrdata[31:24] == 8'h0)
        else $error("load upper bits not zero");
    ctrl_upper_a: assert property (rd && haddr[7:0] == 8'h08 |=> ##1 hrdata[31:3] == 29'h0)
        else $error("control upper bits not zero");
    cover property (rd && haddr[7:0] == 8'h0C);
    cover property ($rose(first_timer_irq));
    cover property ($rose(second_timer_irq));
    cover property (take && hwrite);
endmodule
bind timer_pair timer_pair_checker timer_pair_checker_inst
(
    .mclk(mclk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .first_timer_irq(first_timer_irq),
    .second_timer_irq(second_timer_irq)
);
`default_nettype wire

// ### timer_pair_tb_top.sv
// Self-checking bench for the timer pair registers, interrupts and tick rate.
`timescale 1ns/100ps
`default_nettype none
module timer_pair_tb_top;
    typedef struct {logic wr; logic [7:0] a; logic [31:0] d;} row_t;
    logic        mclk;
    logic        reset_n;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [31:0] hwdata;
    wire  [31:0] hrdata;
    wire         hreadyout;
    wire         first_irq;
    wire         second_irq;
    wire         hresp_seen;
    logic [31:0] rdat;
    logic [31:0] first;
    logic [7:0]  a8;
    int          miscompares;
    int          n_compared;
    int          cycles;
    int          n;
    row_t rows [14] = '{
        '{1'b1, 8'h00, 32'hFFFFFFFF}, '{1'b0, 8'h00, 32'h00FFFFFF},
        '{1'b1, 8'h14, 32'h12345678}, '{1'b0, 8'h14, 32'h00345678},
        '{1'b1, 8'h08, 32'hFFFFFFF8}, '{1'b0, 8'h08, 32'h00000000},
        '{1'b1, 8'h1C, 32'h00000006}, '{1'b0, 8'h1C, 32'h00000006},
        '{1'b1, 8'h04, 32'h00001234}, '{1'b0, 8'h04, 32'h00000000},
        '{1'b1, 8'h24, 32'h00000001}, '{1'b0, 8'h24, 32'h00000000},
        '{1'b1, 8'h3C, 32'h00000055}, '{1'b0, 8'h3C, 32'h00000000}};
    // Only one slave, so its ready is the bus ready.
    timer_pair timer_pair_inst
    (
        .mclk(mclk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp_seen), .first_timer_irq(first_irq),
        .second_timer_irq(second_irq)
    );
    initial
    begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= wr;
        @(posedge mclk);
        while (hreadyout !== 1'b1) @(posedge mclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge mclk);
        while (hreadyout !== 1'b1) @(posedge mclk);
        rd = hrdata;
    endtask
    task automatic finish_test;
        $display("compared %0d miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 4000)
        begin
            miscompares++;
            finish_test();
        end
    end
    initial
    begin
        {reset_n, hsel, haddr, htrans, hwrite, hwdata} <= '0;
        repeat (4) @(posedge mclk);
        reset_n <= 1'b1;
        for (a8 = 8'h00; a8 < 8'h28; a8 += 8'h04)
        begin
            bus(1'b0, a8, 32'h0, rdat);
            check("reset value", rdat, 32'h0);
        end
        foreach (rows[i])
        begin
            bus(rows[i].wr, rows[i].a, rows[i].d, rdat);
            if (!rows[i].wr)
                check("table read", rdat, rows[i].d);
        end
        bus(1'b1, 8'h00, 32'h3, rdat);
        bus(1'b1, 8'h08, 32'h3, rdat);
        for (n = 0; n < 200 && first_irq !== 1'b1; n++) @(posedge mclk);
        check("user mode irq", {31'h0, first_irq}, 32'h1);
        bus(1'b1, 8'h08, 32'h2, rdat);
        bus(1'b0, 8'h04, 32'h0, rdat);
        check("count held", {31'h0, rdat <= 32'h3}, 32'h1);
        bus(1'b0, 8'h10, 32'h0, rdat);
        check("flag pending", rdat, 32'h1);
        bus(1'b1, 8'h08, 32'h6, rdat);
        bus(1'b0, 8'h10, 32'h0, rdat);
        check("masked flag", rdat, 32'h0);
        check("masked irq", {31'h0, first_irq}, 32'h0);
        bus(1'b1, 8'h08, 32'h2, rdat);
        bus(1'b0, 8'h10, 32'h0, rdat);
        check("unmasked flag", rdat, 32'h1);
        bus(1'b0, 8'h0C, 32'h0, rdat);
        check("clear read", rdat, 32'h0);
        bus(1'b0, 8'h10, 32'h0, rdat);
        check("flag cleared", rdat, 32'h0);
        check("irq cleared", {31'h0, first_irq}, 32'h0);
        bus(1'b1, 8'h00, 32'h0, rdat);
        bus(1'b1, 8'h08, 32'h1, rdat);
        for (n = 0; n < 200 && first_irq !== 1'b1; n++) @(posedge mclk);
        bus(1'b0, 8'h04, 32'h0, rdat);
        check("free reload", {31'h0, rdat >= 32'h00FFFF00}, 32'h1);
        // Exactly 250 clocks between snapshots gives 40 ticks at any phase.
        bus(1'b1, 8'h1C, 32'h1, rdat);
        repeat (20) @(posedge mclk);
        bus(1'b0, 8'h18, 32'h0, first);
        repeat (247) @(posedge mclk);
        bus(1'b0, 8'h18, 32'h0, rdat);
        check("tick count", first - rdat, 32'h28);
        // Second timer: short user count, stopped before its flag is read and cleared.
        bus(1'b1, 8'h1C, 32'h0, rdat);
        bus(1'b1, 8'h14, 32'h2, rdat);
        bus(1'b1, 8'h1C, 32'h3, rdat);
        for (n = 0; n < 200 && second_irq !== 1'b1; n++) @(posedge mclk);
        check("second irq", {31'h0, second_irq}, 32'h1);
        bus(1'b1, 8'h1C, 32'h2, rdat);
        bus(1'b0, 8'h24, 32'h0, rdat);
        check("second flag", rdat, 32'h1);
        bus(1'b0, 8'h20, 32'h0, rdat);
        check("second clear read", rdat, 32'h0);
        bus(1'b0, 8'h24, 32'h0, rdat);
        check("second flag cleared", rdat, 32'h0);
        check("second irq cleared", {31'h0, second_irq}, 32'h0);
        check("okay response", {31'h0, hresp_seen}, 32'h0);
        reset_n <= 1'b0;
        repeat (4) @(posedge mclk);
        reset_n <= 1'b1;
        check("irq after reset", {31'h0, first_irq}, 32'h0);
        bus(1'b0, 8'h08, 32'h0, rdat);
        check("control after reset", rdat, 32'h0);
        finish_test();
    end
endmodule
`default_nettype wire
